// ===== src/counter_compare_output_unit.sv
// 8-bit timer counter with two compare channels and port override
//
// Notes on behaviour
// - Clock source select zero stops the counter; else selected source ticks.
// - Each tick clears, increments or decrements the counter per mode.
// - Processor may read and write the counter at any time.
// - Processor counter write beats a simultaneous hardware clear or count.
// - Three-bit mode: two low bits from control A, high bit from B.
// - Wrap flag set at the mode's wrap point and can request interrupt.
// - Per-channel 8-bit comparator flags equality of counter and compare value.
// - Match sets the channel flag on the following tick; enabled flag interrupts.
// - Match flag clears on interrupt service or on a written one.
// - PWM modes double buffer compare values, loading at top or bottom.
// - Processor compare access targets buffer when buffered, else active value.
// - Force strobe in non-PWM modes acts like a match, no flag, no clear.
// - Counter write blocks every compare match on the next tick.
// - Channel output state survives waveform mode changes.
// - Output action fields take effect immediately, not buffered.
// - Output action field sets what the next match does to output state.
// - Nonzero output action replaces port value; direction bit still rules.
// - Channel output reaches pin only while direction bit selects output.
// - Max, bottom and match together handle extreme compare values.
// - Bottom at zero, max at all ones; top is max or compare A.
// - Output action zero leaves output state unchanged on a match.
`timescale 1ns/1ps
`default_nettype none

module counter_compare_output_unit (
  input  wire logic                                   clock,
  input  wire logic                                   nrst,
  input  wire logic [7:0]                             tickSources,
  input  wire logic [timer_compare_pkg::SEL_W-1:0]    clockSourceSelect,
  input  wire logic                                   waveformModeBit0,
  input  wire logic                                   waveformModeBit1,
  input  wire logic                                   waveformModeBit2,
  input  wire logic [timer_compare_pkg::ACT_W-1:0]    outputActionSelectA,
  input  wire logic [timer_compare_pkg::ACT_W-1:0]    outputActionSelectB,
  input  wire logic                                   forceMatchStrobeA,
  input  wire logic                                   forceMatchStrobeB,
  input  wire logic                                   counterWrite,
  input  wire logic [timer_compare_pkg::CNT_W-1:0]    counterWriteData,
  input  wire logic                                   compareWriteA,
  input  wire logic                                   compareWriteB,
  input  wire logic [timer_compare_pkg::CNT_W-1:0]    compareWriteData,
  input  wire logic                                   matchFlagClearA,
  input  wire logic                                   matchFlagClearB,
  input  wire logic                                   wrapFlagClear,
  input  wire logic                                   matchIrqAckA,
  input  wire logic                                   matchIrqAckB,
  input  wire logic                                   wrapIrqAck,
  input  wire logic                                   matchIrqEnableA,
  input  wire logic                                   matchIrqEnableB,
  input  wire logic                                   wrapIrqEnable,
  input  wire logic [timer_compare_pkg::CHANNELS-1:0] portOutputValue,
  input  wire logic [timer_compare_pkg::CHANNELS-1:0] portDirection,
  output logic      [timer_compare_pkg::CNT_W-1:0]    counterValue,
  output logic      [timer_compare_pkg::CNT_W-1:0]    compareValueA,
  output logic      [timer_compare_pkg::CNT_W-1:0]    compareValueB,
  output logic                                        matchFlagA,
  output logic                                        matchFlagB,
  output logic                                        wrapFlag,
  output logic                                        matchIrqA,
  output logic                                        matchIrqB,
  output logic                                        wrapIrq,
  output logic      [timer_compare_pkg::CHANNELS-1:0] channelOutputState,
  output logic      [timer_compare_pkg::CHANNELS-1:0] channelPinValue,
  output logic      [timer_compare_pkg::CHANNELS-1:0] channelPinOutputEnable
);
  import timer_compare_pkg::*;

  // ---------------------------------------------------------------------------
  // mode decoding
  // ---------------------------------------------------------------------------
  function automatic logic isFastPwm(input logic [2:0] mode);
    isFastPwm = (mode == MODE_FAST_MAX) || (mode == MODE_FAST_CMPA);
  endfunction

  function automatic logic isPhasePwm(input logic [2:0] mode);
    isPhasePwm = (mode == MODE_PHASE_MAX) || (mode == MODE_PHASE_CMPA);
  endfunction

  function automatic logic isPwm(input logic [2:0] mode);
    isPwm = isFastPwm(mode) || isPhasePwm(mode);
  endfunction

  // top comes from compare A in clear-on-match and the compare-A PWM modes
  function automatic logic topIsCompareA(input logic [2:0] mode);
    topIsCompareA = (mode == MODE_CTC) || (mode == MODE_PHASE_CMPA)
                    || (mode == MODE_FAST_CMPA);
  endfunction

  // ---------------------------------------------------------------------------
  // output state update on a match
  // ---------------------------------------------------------------------------
  // non-PWM: set, clear or toggle; PWM: polarity picks set or clear
  function automatic logic matchAction(input logic       oc,
                                       input logic [1:0] action,
                                       input logic [2:0] mode,
                                       input count_dir_e dir);
    logic res;
    res = oc;
    if (action == ACT_NONE) begin
      res = oc;
    end else if (!isPwm(mode)) begin
      case (action)
        ACT_TOGGLE: res = ~oc;
        ACT_CLEAR:  res = 1'b0;
        ACT_SET:    res = 1'b1;
        default:    res = oc;
      endcase
    end else if (action == ACT_CLEAR) begin
      res = isPhasePwm(mode) && (dir == DIR_DOWN);
    end else if (action == ACT_SET) begin
      res = !(isPhasePwm(mode) && (dir == DIR_DOWN));
    end
    matchAction = res;
  endfunction

  // fast PWM restores the idle level when the counter drops to bottom
  function automatic logic bottomAction(input logic oc, input logic [1:0] action);
    logic res;
    res = oc;
    case (action)
      ACT_CLEAR: res = 1'b1;
      ACT_SET:   res = 1'b0;
      default:   res = oc;
    endcase
    bottomAction = res;
  endfunction

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  timer_state_s state_q;
  timer_state_s state_d;

  // decoded controls and per-tick events
  logic [2:0] waveformModeSelect;
  logic       timerTick;
  logic [7:0] topValue;
  logic       atTop;
  logic       atBottom;
  logic       atMax;
  logic [1:0] compareMatch;
  logic [1:0] forceMatch;
  logic [1:0] actionSel [CHANNELS];
  logic       wrapPoint;
  logic       reloadPoint;
  logic       counterCleared;

  assign waveformModeSelect = {waveformModeBit2, waveformModeBit1, waveformModeBit0};
  assign actionSel[CH_A]    = outputActionSelectA;
  assign actionSel[CH_B]    = outputActionSelectB;

  // ---------------------------------------------------------------------------
  // tick and count extremes
  // ---------------------------------------------------------------------------
  // no source selected means no tick; source bit zero is never used
  assign timerTick = (clockSourceSelect != SEL_STOPPED)
                     && tickSources[clockSourceSelect];

  // top tracks the active compare a, so a buffered write moves it only at reload
  assign atBottom = (state_q.counterValue == CNT_BOTTOM);
  assign atMax    = (state_q.counterValue == CNT_MAX);
  assign topValue = topIsCompareA(waveformModeSelect) ? state_q.compareActiveA
                                                      : CNT_MAX;
  assign atTop    = (state_q.counterValue == topValue);

  // comparators run all the time
  assign compareMatch[CH_A] = (state_q.counterValue == state_q.compareActiveA);
  assign compareMatch[CH_B] = (state_q.counterValue == state_q.compareActiveB);

  // force strobes are ignored in the pwm modes
  assign forceMatch[CH_A] = forceMatchStrobeA && !isPwm(waveformModeSelect);
  assign forceMatch[CH_B] = forceMatchStrobeB && !isPwm(waveformModeSelect);

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  always_comb begin
    logic [1:0] liveMatch;
    logic       oc;
    liveMatch      = '0;
    oc             = 1'b0;
    wrapPoint      = 1'b0;
    reloadPoint    = 1'b0;
    counterCleared = 1'b0;
    state_d        = state_q;

    // counting
    if (timerTick) begin
      case (waveformModeSelect)
        MODE_PHASE_MAX, MODE_PHASE_CMPA: begin
          // dual slope: turn down at top, turn up again at bottom
          if (state_q.direction == DIR_UP) begin
            if (atTop) begin
              state_d.direction    = DIR_DOWN;
              state_d.counterValue = state_q.counterValue - CNT_ONE;
              reloadPoint          = 1'b1;
            end else begin
              state_d.counterValue = state_q.counterValue + CNT_ONE;
            end
          end else begin
            if (atBottom) begin
              state_d.direction    = DIR_UP;
              state_d.counterValue = state_q.counterValue + CNT_ONE;
            end else begin
              state_d.counterValue = state_q.counterValue - CNT_ONE;
              wrapPoint = (state_q.counterValue == CNT_ONE);
            end
          end
        end
        MODE_CTC, MODE_FAST_MAX, MODE_FAST_CMPA: begin
          // single slope: back to bottom after top
          state_d.direction = DIR_UP;
          if (atTop) begin
            state_d.counterValue = CNT_BOTTOM;
            counterCleared       = isFastPwm(waveformModeSelect);
            reloadPoint          = isFastPwm(waveformModeSelect);
            wrapPoint            = isFastPwm(waveformModeSelect) || atMax;
          end else begin
            state_d.counterValue = state_q.counterValue + CNT_ONE;
            wrapPoint            = atMax;
          end
        end
        default: begin
          state_d.direction    = DIR_UP;
          state_d.counterValue = state_q.counterValue + CNT_ONE;
          wrapPoint            = atMax;
        end
      endcase
    end

    // processor write overrides any clear or count
    if (counterWrite) begin
      state_d.counterValue = counterWriteData;
    end

    // a counter write blocks matches on the next tick, even while stopped
    if (counterWrite) begin
      state_d.blockMatch = 1'b1;
    end else if (timerTick) begin
      state_d.blockMatch = 1'b0;
    end

    // a match is judged on the tick that leaves the matching count
    if (timerTick && !state_q.blockMatch) begin
      liveMatch = compareMatch;
    end

    // compare values: direct when unbuffered, else load at top or bottom
    if (compareWriteA) begin
      state_d.compareValueA = compareWriteData;
    end
    if (compareWriteB) begin
      state_d.compareValueB = compareWriteData;
    end
    if (!isPwm(waveformModeSelect)) begin
      state_d.compareActiveA = state_d.compareValueA;
      state_d.compareActiveB = state_d.compareValueB;
    end else if (reloadPoint) begin
      state_d.compareActiveA = state_q.compareValueA;
      state_d.compareActiveB = state_q.compareValueB;
    end

    // output states hold across mode changes; only events move them
    for (int ch = 0; ch < CHANNELS; ch++) begin
      oc = state_q.channelOutputState[ch];
      if (liveMatch[ch] || forceMatch[ch]) begin
        oc = matchAction(oc, actionSel[ch], waveformModeSelect,
                         state_q.direction);
      end
      if (counterCleared) begin
        oc = bottomAction(oc, actionSel[ch]);
      end
      state_d.channelOutputState[ch] = oc;
    end

    // flags: hardware set wins over a clear in the same cycle
    if (liveMatch[CH_A]) begin
      state_d.matchFlagA = 1'b1;
    end else if (matchFlagClearA || matchIrqAckA) begin
      state_d.matchFlagA = 1'b0;
    end
    if (liveMatch[CH_B]) begin
      state_d.matchFlagB = 1'b1;
    end else if (matchFlagClearB || matchIrqAckB) begin
      state_d.matchFlagB = 1'b0;
    end
    if (wrapPoint) begin
      state_d.wrapFlag = 1'b1;
    end else if (wrapFlagClear || wrapIrqAck) begin
      state_d.wrapFlag = 1'b0;
    end

    // requests follow the flag being registered, so they rise with it
    state_d.irqMatchA = state_d.matchFlagA && matchIrqEnableA;
    state_d.irqMatchB = state_d.matchFlagB && matchIrqEnableB;
    state_d.irqWrap   = state_d.wrapFlag && wrapIrqEnable;

    // port override: any nonzero action routes the output state to the pin
    for (int ch = 0; ch < CHANNELS; ch++) begin
      state_d.pinValue[ch] = (actionSel[ch] != ACT_NONE)
                             ? state_d.channelOutputState[ch]
                             : portOutputValue[ch];
      state_d.pinOutputEnable[ch] = portDirection[ch];
    end
  end

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  // synchronous reset; every register runs on every edge
  always_ff @(posedge clock) begin
    if (!nrst) begin
      state_q <= STATE_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  // every output is a register bit of the state
  assign counterValue           = state_q.counterValue;
  assign compareValueA          = state_q.compareValueA;
  assign compareValueB          = state_q.compareValueB;
  assign matchFlagA             = state_q.matchFlagA;
  assign matchFlagB             = state_q.matchFlagB;
  assign wrapFlag               = state_q.wrapFlag;
  assign matchIrqA              = state_q.irqMatchA;
  assign matchIrqB              = state_q.irqMatchB;
  assign wrapIrq                = state_q.irqWrap;
  assign channelOutputState     = state_q.channelOutputState;
  assign channelPinValue        = state_q.pinValue;
  assign channelPinOutputEnable = state_q.pinOutputEnable;

endmodule

`default_nettype wire

// ===== src/timer_compare_pkg.sv
// constants, mode codes and state layout of the counter and compare output unit
package timer_compare_pkg;

  // ---------------------------------------------------------------------------
  // widths and count extremes
  // ---------------------------------------------------------------------------
  localparam int          CNT_W        = 8;
  localparam int          SEL_W        = 3;
  localparam int          MODE_W       = 3;
  localparam int          ACT_W        = 2;
  localparam int          CHANNELS     = 2;
  localparam int          CH_A         = 0;
  localparam int          CH_B         = 1;
  localparam logic [7:0]  CNT_BOTTOM   = 8'h00;
  localparam logic [7:0]  CNT_MAX      = 8'hff;
  localparam logic [7:0]  CNT_ONE      = 8'h01;
  localparam logic [2:0]  SEL_STOPPED  = 3'h0;

  // ---------------------------------------------------------------------------
  // waveform modes
  // ---------------------------------------------------------------------------
  localparam logic [2:0]  MODE_NORMAL     = 3'h0;
  localparam logic [2:0]  MODE_PHASE_MAX  = 3'h1;
  localparam logic [2:0]  MODE_CTC        = 3'h2;
  localparam logic [2:0]  MODE_FAST_MAX   = 3'h3;
  localparam logic [2:0]  MODE_PHASE_CMPA = 3'h5;
  localparam logic [2:0]  MODE_FAST_CMPA  = 3'h7;

  // ---------------------------------------------------------------------------
  // output actions
  // ---------------------------------------------------------------------------
  localparam logic [1:0]  ACT_NONE     = 2'h0;
  localparam logic [1:0]  ACT_TOGGLE   = 2'h1;
  localparam logic [1:0]  ACT_CLEAR    = 2'h2;
  localparam logic [1:0]  ACT_SET      = 2'h3;

  // ---------------------------------------------------------------------------
  // count direction and state
  // ---------------------------------------------------------------------------
  typedef enum logic {
    DIR_UP   = 1'b0,
    DIR_DOWN = 1'b1
  } count_dir_e;

  typedef struct packed {
    logic [7:0] counterValue;
    count_dir_e direction;
    logic [7:0] compareActiveA;
    logic [7:0] compareActiveB;
    logic [7:0] compareValueA;
    logic [7:0] compareValueB;
    logic [1:0] channelOutputState;
    logic       matchFlagA;
    logic       matchFlagB;
    logic       wrapFlag;
    logic       blockMatch;
    logic       irqMatchA;
    logic       irqMatchB;
    logic       irqWrap;
    logic [1:0] pinValue;
    logic [1:0] pinOutputEnable;
  } timer_state_s;

  localparam timer_state_s STATE_RESET = '0;

endpackage

// ===== verification/counter_compare_properties.sv
// concurrent checks on the ports of the counter and compare output unit
`timescale 1ns/1ps
`default_nettype none
module counter_compare_properties (
  input wire logic       clock,
  input wire logic       nrst,
  input wire logic [7:0] tickSources,
  input wire logic [2:0] clockSourceSelect,
  input wire logic       waveformModeBit0,
  input wire logic       waveformModeBit1,
  input wire logic       waveformModeBit2,
  input wire logic [1:0] outputActionSelectA,
  input wire logic       forceMatchStrobeA,
  input wire logic       counterWrite,
  input wire logic [7:0] counterWriteData,
  input wire logic       matchFlagClearA,
  input wire logic       matchIrqEnableA,
  input wire logic [7:0] compareValueA,
  input wire logic [7:0] counterValue,
  input wire logic       matchFlagA,
  input wire logic       matchIrqA,
  input wire logic [1:0] channelOutputState
);
  import timer_compare_pkg::*;
  // ---------------------------------------------------------------------------
  // helper logic
  // ---------------------------------------------------------------------------
  logic [2:0] modeSel;
  logic       tick;
  logic       blockPending_q;
  assign modeSel = {waveformModeBit2, waveformModeBit1, waveformModeBit0};
  assign tick    = (clockSourceSelect != SEL_STOPPED) && tickSources[clockSourceSelect];
  // a counter write arms blocking until the next tick has gone by
  always_ff @(posedge clock) begin
    if (!nrst) blockPending_q <= 1'b0;
    else if (counterWrite) blockPending_q <= 1'b1;
    else if (tick) blockPending_q <= 1'b0;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // ---------------------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------------------
  chk_stop_holds: assert property (
    clockSourceSelect == SEL_STOPPED && !counterWrite |=> $stable(counterValue))
    else $error("counter moved while stopped");
  chk_write_wins: assert property (
    counterWrite |=> counterValue == $past(counterWriteData))
    else $error("counter write lost");
  chk_normal_step: assert property (
    modeSel == MODE_NORMAL && tick && !counterWrite
      |=> counterValue == $past(counterValue) + CNT_ONE)
    else $error("normal mode did not count up by one");
  chk_match_flag: assert property (
    modeSel == MODE_NORMAL && tick && !blockPending_q && !counterWrite
      && counterValue == compareValueA |=> matchFlagA)
    else $error("match did not set flag");
  chk_block_match: assert property (
    tick && blockPending_q && !matchFlagA |=> !matchFlagA)
    else $error("blocked match set flag");
  chk_flag_clear: assert property (
    matchFlagClearA && !tick |=> !matchFlagA)
    else $error("flag not cleared by written one");
  chk_irq_follows: assert property (
    matchIrqA == (matchFlagA && $past(matchIrqEnableA)))
    else $error("request does not follow flag and enable");
  chk_force_set: assert property (
    modeSel == MODE_NORMAL && forceMatchStrobeA && outputActionSelectA == ACT_SET
      |=> channelOutputState[0])
    else $error("force did not set output");
  chk_none_holds: assert property (
    outputActionSelectA == ACT_NONE |=> $stable(channelOutputState[0]))
    else $error("output changed with no action");
endmodule

bind counter_compare_output_unit counter_compare_properties chk (
  .clock, .nrst, .tickSources, .clockSourceSelect, .waveformModeBit0,
  .waveformModeBit1, .waveformModeBit2, .outputActionSelectA, .forceMatchStrobeA,
  .counterWrite, .counterWriteData, .matchFlagClearA, .matchIrqEnableA,
  .compareValueA, .counterValue, .matchFlagA, .matchIrqA, .channelOutputState
);
`default_nettype wire

// ===== verification/tb_top.sv
// self-checking bench for the counter and compare output unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin err_total++; \
  $display("[ERR] %s expected %h seen %h", nm, exp, got); end end
module tb_top;
  import timer_compare_pkg::*;
  typedef struct packed {logic [1:0] act; logic [1:0] pov; logic [1:0] st; logic [1:0] pin;} row_s;
  // strobe bits: 0 counter, 1/2 compare, 3/4 force, 5-7 flag clear, 8-10 irq ack
  localparam logic [10:0] P_CNT = 11'h001;
  localparam logic [10:0] P_CMPA = 11'h002;
  localparam logic [10:0] P_CMPB = 11'h004;
  logic        clock, nrst;
  logic [7:0]  tickSources, wdata, counterValue, compareValueA, compareValueB;
  logic [2:0]  clockSourceSelect, modeSel, irqEn;
  logic [1:0]  actA, actB, portOutputValue, portDirection;
  logic [1:0]  channelOutputState, channelPinValue, channelPinOutputEnable;
  logic [10:0] pulse;
  logic        matchFlagA, matchFlagB, wrapFlag, matchIrqA, matchIrqB, wrapIrq;
  int          err_total, tests_run;
  row_s        rows [6] = '{'{ACT_SET, 2'h0, 2'h3, 2'h3}, '{ACT_TOGGLE, 2'h0, 2'h0, 2'h0},
                           '{ACT_TOGGLE, 2'h0, 2'h3, 2'h3}, '{ACT_NONE, 2'h0, 2'h3, 2'h0},
                           '{ACT_CLEAR, 2'h3, 2'h0, 2'h0}, '{ACT_NONE, 2'h2, 2'h0, 2'h2}};
  counter_compare_output_unit dut (
    .clock, .nrst, .tickSources, .clockSourceSelect, .waveformModeBit0(modeSel[0]),
    .waveformModeBit1(modeSel[1]), .waveformModeBit2(modeSel[2]),
    .outputActionSelectA(actA), .outputActionSelectB(actB),
    .forceMatchStrobeA(pulse[3]), .forceMatchStrobeB(pulse[4]), .counterWrite(pulse[0]),
    .counterWriteData(wdata), .compareWriteA(pulse[1]), .compareWriteB(pulse[2]),
    .compareWriteData(wdata), .matchFlagClearA(pulse[5]), .matchFlagClearB(pulse[6]),
    .wrapFlagClear(pulse[7]), .matchIrqAckA(pulse[8]), .matchIrqAckB(pulse[9]),
    .wrapIrqAck(pulse[10]), .matchIrqEnableA(irqEn[0]), .matchIrqEnableB(irqEn[1]),
    .wrapIrqEnable(irqEn[2]), .portOutputValue, .portDirection, .counterValue,
    .compareValueA, .compareValueB, .matchFlagA, .matchFlagB, .wrapFlag, .matchIrqA,
    .matchIrqB, .wrapIrq, .channelOutputState, .channelPinValue, .channelPinOutputEnable
  );
  // ---------------------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic strobe(input logic [10:0] m, input logic [7:0] d);
    @(posedge clock);
    pulse <= m;
    wdata <= d;
    @(posedge clock);
    pulse <= '0;
    #1;
  endtask
  task automatic ticks(input int n);
    @(posedge clock);
    tickSources <= 8'h02;
    repeat (n) @(posedge clock);
    tickSources <= 8'h00;
    #1;
  endtask
  task automatic print_verdict();
    if (err_total == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------------------
  // clock, watchdog and tests
  // ---------------------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  initial begin
    repeat (3000) @(posedge clock);
    err_total++;
    print_verdict();
  end
  initial begin
    {nrst, tickSources, wdata, clockSourceSelect, modeSel, irqEn, actA, actB} = '0;
    {portOutputValue, pulse, err_total, tests_run} = '0;
    portDirection = 2'h3;
    repeat (8) @(posedge clock);
    nrst <= 1'b1;
    #1;
    `CHK("reset regs", 24'h0, {counterValue, compareValueA, compareValueB})
    `CHK("reset flags", 5'h0, {matchFlagA, matchFlagB, wrapFlag, channelOutputState})
    foreach (rows[i]) begin
      @(posedge clock);
      actA <= rows[i].act;
      actB <= rows[i].act;
      portOutputValue <= rows[i].pov;
      strobe(11'h018, 8'h00);
      cyc(1);
      `CHK("state", rows[i].st, channelOutputState)
      `CHK("pin", rows[i].pin, channelPinValue)
      `CHK("force flag", 1'b0, matchFlagA)
    end
    @(posedge clock);
    portDirection <= 2'h1;
    actA <= ACT_TOGGLE;
    actB <= ACT_SET;
    irqEn <= 3'h1;
    clockSourceSelect <= 3'h1;
    cyc(2);
    `CHK("oe", 2'h1, channelPinOutputEnable)
    strobe(P_CMPA, 8'hfe);
    strobe(P_CMPB, 8'hff);
    strobe(P_CNT, 8'hfd);
    `CHK("written", 8'hfd, counterValue)
    ticks(3);
    `CHK("wrapped", 8'h00, counterValue)
    `CHK("match flags", 2'h3, {matchFlagA, matchFlagB})
    `CHK("wrap flag", 1'b1, wrapFlag)
    `CHK("outputs", 2'h3, channelOutputState)
    cyc(1);
    `CHK("irqs", 3'h4, {matchIrqA, matchIrqB, wrapIrq})
    strobe(11'h2a0, 8'h00);
    `CHK("cleared", 3'h0, {matchFlagA, matchFlagB, wrapFlag})
    @(posedge clock);
    tickSources <= 8'h02;
    pulse <= P_CNT;
    wdata <= 8'hfe;
    @(posedge clock);
    pulse <= '0;
    @(posedge clock);
    tickSources <= 8'h00;
    #1;
    `CHK("write wins", 8'hff, counterValue)
    `CHK("blocked", 1'b0, matchFlagA)
    @(posedge clock);
    clockSourceSelect <= SEL_STOPPED;
    tickSources <= 8'hff;
    cyc(3);
    `CHK("stopped", 8'hff, counterValue)
    @(posedge clock);
    tickSources <= 8'h00;
    clockSourceSelect <= 3'h1;
    modeSel <= MODE_FAST_MAX;
    actA <= ACT_CLEAR;
    strobe(11'h008, 8'h00);
    `CHK("pwm force", 2'h3, channelOutputState)
    strobe(P_CMPA, 8'h22);
    strobe(P_CNT, 8'h20);
    ticks(3);
    `CHK("buffered", 1'b0, matchFlagA)
    `CHK("buffer view", 8'h22, compareValueA)
    @(posedge clock);
    modeSel <= MODE_CTC;
    strobe(P_CMPA, 8'h05);
    strobe(P_CNT, 8'h03);
    ticks(3);
    `CHK("ctc clear", 8'h00, counterValue)
    `CHK("ctc match", 1'b1, matchFlagA)
    `CHK("ctc no wrap", 1'b0, wrapFlag)
    @(posedge clock);
    modeSel <= MODE_PHASE_CMPA;
    strobe(P_CMPA, 8'h03);
    strobe(P_CNT, 8'h04);
    ticks(4);
    `CHK("phase top", 8'h02, counterValue)
    `CHK("phase reload", 2'h3, channelOutputState)
    print_verdict();
  end
endmodule
`default_nettype wire
